// ### rtl/operating_mode_supervisor.sv
// Overview of operation
// - Reset-pin or input rising edge wakes to Normal.
// - Input activity flag drops after idle timeout.
// - Both flags low, pin low: Sleep.
// - Normal or Fail-safe: inputs drive channels.
// - Wake-up is pin OR either activity flag.
// - Fail-safe from supply loss or watchdog timeout.
// - Fault from channel faults, undervoltage, qualified overvoltage.
// - Mode table selects Sleep, Normal, Fail-safe, Fault.
// - Watchdog runs with supply, enabled, pin high.
// - Disable bit blocks Fail-safe after watchdog timeout.
// - Sleep: channels off, registers held at default.
// - Power-up state is Sleep.
// - Fail-safe drives output low, inputs drive channels.
// - Fail-safe entry resets registers but the parallel bit, blocks register writes.
// - Reset-pin rising edge starts the watchdog.
// - Toggle bit unchanged for period: Fail-safe.
// - Top-bit word then second word leaves Fail-safe.
// - Normal return releases output, keeps power-on, parallel.
`timescale 1ns/1ns
`default_nettype none

module operating_mode_supervisor (
  input  wire logic        core_clk_in,          // Core clock, 10 MHz.
  input  wire logic        nrst_in,              // Async reset, active low.
  // APB slave.
  input  wire logic        psel_in,              // Slave select.
  input  wire logic        penable_in,           // Access phase.
  input  wire logic        pwrite_in,            // Write direction.
  input  wire logic [7:0]  paddr_in,             // Byte address.
  input  wire logic [31:0] pwdata_in,            // Write data.
  output logic             pready_out,           // Always ready.
  output logic             pslverr_out,          // Error answer.
  output logic [31:0]      prdata_out,           // Read data.
  // Pins and analogue status (asynchronous).
  input  wire logic        wake_reset_pin_n_in,  // Reset/wake pin.
  input  wire logic [1:0]  direct_in,            // Direct inputs.
  input  wire logic        logic_supply_ok_in,   // Logic supply present.
  input  wire logic [1:0]  overcurrent_fault_in, // Per channel.
  input  wire logic [1:0]  overtemperature_fault_in, // Per channel.
  input  wire logic [1:0]  severe_short_fault_in,    // Per channel.
  input  wire logic        undervoltage_fault_in,    // Supply low.
  input  wire logic        supply_high_fault_in,     // Supply high.
  // Outputs.
  output logic             failsafe_output_n_out,    // Low in Fail-safe.
  output logic [1:0]       channel_on_out,           // Channel drive.
  output logic             normal_mode_flag_out,     // Normal mode.
  output logic [1:0]       mode_out,                 // Current mode.
  output logic             delatch_out               // Delatch pulse.
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  // All state in one record; the comb block computes its next copy.
  typedef struct packed {
    logic [1:0]                        rst_sync;   // Pin synchroniser.
    logic [1:0]                        sup_sync;   // Supply synchroniser.
    logic [1:0]                        in0_sync;   // Input 0 sync.
    logic [1:0]                        in1_sync;   // Input 1 sync.
    logic [1:0]                        flt_sync;   // Merged fault sync.
    logic                              rst_prev;   // Pin, last cycle.
    logic [1:0]                        in_prev;    // Inputs, last cycle.
    logic [1:0]                        in_on;      // Activity flags.
    logic [1:0][opmode_pkg::CNT_W-1:0] idle_cnt;   // Inactivity timers.
    logic                              wd_run;     // Watchdog started.
    logic [opmode_pkg::CNT_W-1:0]      wd_cnt;     // Watchdog timer.
    logic                              wd_last;    // Last toggle bit.
    logic                              wd_expired; // Timeout seen.
    logic                              fs_armed;   // Exit word seen.
    logic                              sup_seen;   // Supply was present.
    logic                              sup_lost;   // Supply-loss cause.
    logic [7:0]                        cfg;        // Configuration.
    logic                              power_on;   // Power-on flag.
    opmode_pkg::mode_e                 mode;       // Operating mode.
    logic                              delatch;    // Delatch pulse.
    logic [31:0]                       rdata;      // Read data.
    logic                              slverr;     // Error answer.
  } state_s;

  state_s st;       // Registered state.
  state_s next_st;  // Next state.

  // Combinational helper terms.
  logic wake_up;     // Wake-up term.
  logic fail_safe;   // Fail-safe term.
  logic fault;       // Fault term.
  logic rst_pin;     // Synchronised reset pin.
  logic sup_ok;      // Synchronised supply status.
  logic [1:0] din;   // Synchronised direct inputs.
  logic apb_acc;     // APB access phase.
  logic word_wr;     // A serial word arrives.
  logic reg_open;    // Register writes allowed.
  opmode_pkg::mode_e sel_mode; // Mode from the table.

  // Counter saturating increment, used by every timer.
  function automatic logic [opmode_pkg::CNT_W-1:0] bump(
    input logic [opmode_pkg::CNT_W-1:0] c
  );
    bump = (c == '1) ? c : c + 1'b1;
  endfunction : bump

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // All behaviour lives here; external levels are read only after the
  // second flip-flop of their synchroniser.
  always_comb begin
    next_st = st;
    rst_pin = st.rst_sync[1];
    sup_ok  = st.sup_sync[1];
    din     = {st.in1_sync[1], st.in0_sync[1]};
    // Synchronisers: first stage feeds only the second.
    next_st.rst_sync = {st.rst_sync[0], wake_reset_pin_n_in};
    next_st.sup_sync = {st.sup_sync[0], logic_supply_ok_in};
    next_st.in0_sync = {st.in0_sync[0], direct_in[0]};
    next_st.in1_sync = {st.in1_sync[0], direct_in[1]};
    next_st.flt_sync = {st.flt_sync[0],
      (|overcurrent_fault_in) | (|overtemperature_fault_in) |
      (|severe_short_fault_in) | undervoltage_fault_in |
      (supply_high_fault_in &
       st.cfg[opmode_pkg::CFG_SUPPLY_HIGH_QUALIFIER_BIT])};
    next_st.rst_prev = rst_pin;
    next_st.in_prev  = din;
    next_st.delatch  = 1'b0;
    if (sup_ok) begin
      next_st.sup_seen = 1'b1;
    end
    // Supply loss counts whenever the enable is set while a supply once seen is low. The
    // cause is held, because Fail-safe entry clears the enable itself.
    if (st.sup_seen && !sup_ok &&
        st.cfg[opmode_pkg::CFG_SUPPLY_LOSS_EN_BIT]) begin
      next_st.sup_lost = 1'b1;
    end

    // Input activity: any edge restarts the idle timer; a rising edge
    // also sets the flag, which is what wakes a device on inputs alone.
    for (int i = 0; i < 2; i++) begin
      if (din[i] != st.in_prev[i]) begin
        next_st.idle_cnt[i] = '0;
        if (din[i]) begin
          next_st.in_on[i] = 1'b1;
        end
      end else if (st.idle_cnt[i] >= opmode_pkg::INPUT_IDLE_CYCLES) begin
        next_st.in_on[i] = 1'b0;
      end else begin
        next_st.idle_cnt[i] = bump(st.idle_cnt[i]);
      end
    end

    // APB decode; the slave answers in the access cycle, no wait state.
    apb_acc  = psel_in & penable_in;
    word_wr  = apb_acc & pwrite_in &
               (paddr_in == opmode_pkg::SERIAL_WORD_ADDR) &
               (st.mode != opmode_pkg::MODE_SLEEP);
    reg_open = (st.mode == opmode_pkg::MODE_NORMAL) ||
               (st.mode == opmode_pkg::MODE_FAULT && !st.fs_armed);

    // Watchdog: once started, runs in any awake mode with supply, enabled and pin high.
    if (rst_pin && !st.rst_prev && sup_ok) begin
      next_st.wd_run = 1'b1;
      next_st.wd_cnt = '0;
    end else if (st.wd_run && sup_ok && rst_pin &&
        !st.cfg[opmode_pkg::CFG_WATCHDOG_DISABLE_BIT]) begin
      if (word_wr && (pwdata_in[opmode_pkg::WORD_TOGGLE_BIT] !=
          st.wd_last)) begin
        next_st.wd_cnt = '0;
      end else if (st.wd_cnt >= opmode_pkg::WATCHDOG_CYCLES) begin
        next_st.wd_expired = 1'b1;
      end else begin
        next_st.wd_cnt = bump(st.wd_cnt);
      end
    end
    if (word_wr) begin
      next_st.wd_last = pwdata_in[opmode_pkg::WORD_TOGGLE_BIT];
    end

    // Leaving Fail-safe: a word with the top bit set arms the exit and a
    // second word inside the period completes it.
    if (st.mode == opmode_pkg::MODE_FAILSAFE && word_wr) begin
      if (st.fs_armed) begin
        next_st.wd_expired = 1'b0;
        next_st.fs_armed   = 1'b0;
        next_st.wd_cnt     = '0;
        // A supply-loss cause clears only once the supply is back.
        if (sup_ok) begin
          next_st.sup_lost = 1'b0;
        end
      end else if (pwdata_in[opmode_pkg::WORD_TOGGLE_BIT]) begin
        next_st.fs_armed = 1'b1;
        next_st.wd_cnt   = '0;
      end
    end else if (st.fs_armed && st.wd_cnt >= opmode_pkg::WATCHDOG_CYCLES)
    begin
      next_st.fs_armed = 1'b0; // Second word late: start over.
    end

    // Mode terms.
    wake_up   = rst_pin | (|st.in_on);
    fail_safe = st.sup_lost |
                (st.wd_expired &
                 ~st.cfg[opmode_pkg::CFG_WATCHDOG_DISABLE_BIT]);
    fault     = st.flt_sync[1];

    // Table: wake-up low wins, then fault, then fail-safe.
    if (!wake_up) begin
      sel_mode = opmode_pkg::MODE_SLEEP;
    end else if (fault) begin
      sel_mode = opmode_pkg::MODE_FAULT;
    end else if (fail_safe) begin
      sel_mode = opmode_pkg::MODE_FAILSAFE;
    end else begin
      sel_mode = opmode_pkg::MODE_NORMAL;
    end
    next_st.mode = sel_mode;

    // Mode-entry effects.
    unique case (sel_mode)
      opmode_pkg::MODE_SLEEP: begin
        // Registers stay at default; writes and serial words are ignored.
        next_st.cfg        = opmode_pkg::CFG_RESET;
        next_st.wd_run     = 1'b0;
        next_st.sup_lost   = 1'b0;
        next_st.wd_expired = 1'b0;
        next_st.fs_armed   = 1'b0;
      end
      opmode_pkg::MODE_FAILSAFE: begin
        if (st.mode != opmode_pkg::MODE_FAILSAFE) begin
          // Keep only the parallel bit; power-on lives apart.
          next_st.cfg = opmode_pkg::CFG_RESET |
            (st.cfg & (8'h01 << opmode_pkg::CFG_PARALLEL_BIT));
          next_st.delatch = 1'b1;
        end
      end
      opmode_pkg::MODE_NORMAL: begin
        if (st.mode == opmode_pkg::MODE_FAILSAFE) begin
          next_st.cfg = opmode_pkg::CFG_RESET |
            (st.cfg & (8'h01 << opmode_pkg::CFG_PARALLEL_BIT));
        end
      end
      opmode_pkg::MODE_FAULT: begin
      end
    endcase

    // Register writes, blocked in Fail-safe.
    if (apb_acc && pwrite_in && reg_open && sel_mode ==
        st.mode && paddr_in ==
        opmode_pkg::GLOBAL_CONFIGURATION_REGISTER_ADDR) begin
      next_st.cfg = pwdata_in[7:0];
    end
    // Reading the status clears the power-on flag.
    if (apb_acc && !pwrite_in && paddr_in == opmode_pkg::STATUS_ADDR) begin
      next_st.power_on = 1'b0;
    end

    // Read data and error answer, registered for the access cycle.
    next_st.rdata  = '0;
    next_st.slverr = 1'b0;
    if (psel_in && !penable_in) begin
      unique case (paddr_in)
        opmode_pkg::GLOBAL_CONFIGURATION_REGISTER_ADDR: begin
          next_st.rdata = {24'h000000, st.cfg};
        end
        opmode_pkg::STATUS_ADDR: begin
          next_st.rdata = {23'h000000, st.power_on, 1'b0, st.wd_run,
                           st.fs_armed, st.in_on, 1'b0, st.mode};
        end
        opmode_pkg::SERIAL_WORD_ADDR: begin
          next_st.rdata = '0;
        end
        default: begin
          next_st.slverr = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Reset lands in Sleep with all flags clear except the power-on flag, which is set.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st          <= '0;
      st.cfg      <= opmode_pkg::CFG_RESET;
      st.power_on <= 1'b1;
      st.mode     <= opmode_pkg::MODE_SLEEP;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Channels follow direct inputs in Fail-safe, and in Normal with the pin low; in
  // Normal with the pin high the PWM engine (outside) owns them, so
  // here they follow the inputs too as the only source we have.
  always_comb begin
    channel_on_out = 2'b00;
    if (st.mode == opmode_pkg::MODE_FAILSAFE ||
        st.mode == opmode_pkg::MODE_NORMAL) begin
      channel_on_out = {st.in1_sync[1], st.in0_sync[1]};
    end
  end

  assign failsafe_output_n_out =
    (st.mode != opmode_pkg::MODE_FAILSAFE);
  assign normal_mode_flag_out = (st.mode == opmode_pkg::MODE_NORMAL);
  assign mode_out             = st.mode;
  assign delatch_out          = st.delatch;
  assign pready_out           = 1'b1;
  assign pslverr_out          = st.slverr & psel_in & penable_in;
  assign prdata_out           = st.rdata;

endmodule : operating_mode_supervisor

`default_nettype wire

// ### rtl/opmode_pkg.sv
`default_nettype none
package opmode_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------

  // Core clock rate in Hz.
  localparam int unsigned CLK_HZ = 10_000_000;
  // Watchdog period in milliseconds.
  localparam int unsigned WATCHDOG_TIMEOUT_PERIOD_MS = 310;
  // Direct-input inactivity time in milliseconds.
  localparam int unsigned INPUT_IDLE_MS = 250;
  // Cycle counts, longest times rounded down.
  localparam int unsigned WATCHDOG_CYCLES =
    (CLK_HZ / 1000) * WATCHDOG_TIMEOUT_PERIOD_MS;
  localparam int unsigned INPUT_IDLE_CYCLES =
    (CLK_HZ / 1000) * INPUT_IDLE_MS;
  // Counter width covers both counts.
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------------

  // Global configuration register, software steers the supervisor.
  localparam logic [7:0] GLOBAL_CONFIGURATION_REGISTER_ADDR = 8'h00;
  // Status register, read only.
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  // Serial word mailbox, writing models reception of one word.
  localparam logic [7:0] SERIAL_WORD_ADDR = 8'h08;

  // Configuration bit positions.
  localparam int unsigned CFG_WATCHDOG_DISABLE_BIT = 4;
  localparam int unsigned CFG_SUPPLY_LOSS_EN_BIT = 0;
  localparam int unsigned CFG_SUPPLY_HIGH_QUALIFIER_BIT = 1;
  localparam int unsigned CFG_PARALLEL_BIT = 2;
  // Power-on flag position in the status register.
  localparam int unsigned STAT_POWER_ON_BIT = 8;
  // Reset value of the configuration register.
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Top bit of a serial word carries the watchdog toggle bit.
  localparam int unsigned WORD_TOGGLE_BIT = 15;

  // ----------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------

  // Operating mode of the device.
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_NORMAL,
    MODE_FAILSAFE,
    MODE_FAULT
  } mode_e;

endpackage : opmode_pkg
`default_nettype wire

// ### tb/host_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host pins; they move on the host clock, unrelated to the core clock.
module host_pin_model (
  input  wire logic       link_clk_in,
  input  wire logic       wake_req_in,
  input  wire logic [1:0] dir_req_in,
  output logic            wake_reset_pin_n_out,
  output logic [1:0]      direct_out
);
  initial wake_reset_pin_n_out = 1'b0;
  initial direct_out = 2'h0;
  // The host holds the pin high while it wants the device awake.
  always @(posedge link_clk_in) begin
    wake_reset_pin_n_out <= wake_req_in;
    direct_out <= dir_req_in;
  end
endmodule : host_pin_model
`default_nettype wire

// ### tb/operating_mode_supervisor_bench.sv
`timescale 1ns/1ns
`default_nettype none
// Timeout counts are package constants, so idle and watchdog expiry
// are not reached here; the run cannot afford millions of cycles.
module operating_mode_supervisor_bench;
  logic core_clk_in, nrst_in, psel, penable, pwrite, sup, link_clk;
  logic wake_req, pin, pready, perr, fsn, nmf, dl;
  logic [1:0] dir_req, dir, ch, mode;
  logic [4:0] fv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int error_cnt, tests_run, cyc;
  initial core_clk_in = 1'b0;
  always #50 core_clk_in = ~core_clk_in;
  initial link_clk = 1'b0;
  always #400 link_clk = ~link_clk;
  host_pin_model host (.link_clk_in(link_clk), .wake_req_in(wake_req),
    .dir_req_in(dir_req), .wake_reset_pin_n_out(pin), .direct_out(dir));
  operating_mode_supervisor dut (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(perr), .prdata_out(prdata),
    .wake_reset_pin_n_in(pin), .direct_in(dir), .logic_supply_ok_in(sup),
    .overcurrent_fault_in({1'b0, fv[0]}),
    .overtemperature_fault_in({fv[1], 1'b0}),
    .severe_short_fault_in({1'b0, fv[2]}),
    .undervoltage_fault_in(fv[3]), .supply_high_fault_in(fv[4]),
    .failsafe_output_n_out(fsn), .channel_on_out(ch),
    .normal_mode_flag_out(nmf), .mode_out(mode), .delatch_out(dl));
  task results;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // A hang counts as a mismatch and closes the run.
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  task check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer; data is taken at the edge that sees pready.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    @(posedge core_clk_in);
    while (pready !== 1'b1) @(posedge core_clk_in);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check("read", r & m, exp);
    check("error", 32'(e), 32'(a > 8'h08));
  endtask : rd
  // Pin changes pass the host clock and a synchroniser: allow slack.
  task settle;
    repeat (16) @(posedge core_clk_in);
  endtask : settle
  task wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    @(posedge core_clk_in);
    while (mode !== m && n < 40) begin
      @(posedge core_clk_in);
      n++;
    end
    check("mode", 32'(mode), 32'(m));
  endtask : wait_mode
  task t_power_up;
    check("mode", 32'(mode), 32'h0);
    check("chan", 32'({fsn, ch, nmf}), 32'h8);
    rd(8'h04, 32'h103, 32'h100);
    rd(8'h0c, 32'h0, 32'h0);
    wr(8'h00, 32'h04);
  endtask : t_power_up
  task t_pin_wake;
    sup <= 1'b1;
    wake_req <= 1'b1;
    wait_mode(2'h1);
    check("nm", 32'(nmf), 32'h1);
    rd(8'h00, 32'hff, 32'h0);
    rd(8'h04, 32'h40, 32'h40);
    wr(8'h08, 32'h8000);
  endtask : t_pin_wake
  task t_faults;
    dir_req <= 2'h3;
    fv <= 5'h10;
    settle();
    check("mode", 32'(mode), 32'h1);
    check("chan", 32'(ch), 32'h3);
    fv <= 5'h0;
    wr(8'h00, 32'h02);
    for (int i = 0; i < 5; i++) begin
      fv <= 5'h1 << i;
      wait_mode(2'h3);
      check("chan", 32'(ch), 32'h0);
      fv <= 5'h0;
      wait_mode(2'h1);
    end
  endtask : t_faults
  task t_failsafe;
    wr(8'h00, 32'h07);
    sup <= 1'b0;
    wait_mode(2'h2);
    check("fsn", 32'(fsn), 32'h0);
    dir_req <= 2'h2;
    settle();
    check("chan", 32'(ch), 32'h2);
    wr(8'h00, 32'h0);
    sup <= 1'b1;
    wr(8'h08, 32'h8000);
    wr(8'h08, 32'h0);
    wait_mode(2'h1);
    check("fsn", 32'(fsn), 32'h1);
    rd(8'h00, 32'hff, 32'h04);
  endtask : t_failsafe
  task t_direct_wake;
    wake_req <= 1'b0;
    dir_req <= 2'h0;
    sup <= 1'b0;
    settle();
    nrst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    @(posedge core_clk_in);
    check("mode", 32'(mode), 32'h0);
    dir_req <= 2'h1;
    wait_mode(2'h1);
    settle();
    check("chan", 32'(ch), 32'h1);
    rd(8'h04, 32'h11b, 32'h109);
  endtask : t_direct_wake
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sup, wake_req, dir_req, fv, nrst_in} = '0;
    {error_cnt, tests_run, cyc} = '0;
    repeat (6) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    t_power_up();
    t_pin_wake();
    t_faults();
    t_failsafe();
    t_direct_wake();
    results();
  end
endmodule : operating_mode_supervisor_bench
`default_nettype wire

// ### tb/operating_mode_supervisor_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the mode supervisor
// ----------------------------------------------------------------------
module opmode_checker (
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic       wake_reset_pin_n_in,
  input wire logic [1:0] direct_in,
  input wire logic       logic_supply_ok_in,
  input wire logic [1:0] overcurrent_fault_in,
  input wire logic [1:0] overtemperature_fault_in,
  input wire logic [1:0] severe_short_fault_in,
  input wire logic       undervoltage_fault_in,
  input wire logic       supply_high_fault_in,
  input wire logic       failsafe_output_n_out,
  input wire logic [1:0] channel_on_out,
  input wire logic [1:0] mode_out,
  input wire logic       delatch_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // Any fault pin; the high-supply one counts as its qualifier is unseen.
  logic flt;
  assign flt = |{overcurrent_fault_in, overtemperature_fault_in,
    severe_short_fault_in, undervoltage_fault_in, supply_high_fault_in};
  logic hard;
  assign hard = |{overcurrent_fault_in, overtemperature_fault_in,
    severe_short_fault_in, undervoltage_fault_in};
  property p_wake;
    ($rose(wake_reset_pin_n_in) && logic_supply_ok_in && !flt &&
     mode_out == 2'h0) ##1 (wake_reset_pin_n_in && logic_supply_ok_in &&
     !flt)[*5] |-> mode_out == 2'h1;
  endproperty
  a_wake: assert property (p_wake) else $error("pin rise gave no wake");
  property p_stay;
    (mode_out == 2'h0 && !wake_reset_pin_n_in && direct_in == 2'h0)[*6]
      |=> mode_out == 2'h0;
  endproperty
  a_stay: assert property (p_stay) else $error("woke without cause");
  property p_sleep;
    (mode_out == 2'h0)[*2] |-> channel_on_out == 2'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("channel on in sleep");
  property p_fltoff;
    (mode_out == 2'h3)[*2] |-> channel_on_out == 2'h0;
  endproperty
  a_fltoff: assert property (p_fltoff) else $error("channel on in fault");
  property p_flt;
    (hard && mode_out != 2'h0)[*6] |-> mode_out == 2'h3;
  endproperty
  a_flt: assert property (p_flt) else $error("fault mode missed");
  property p_follow;
    (mode_out inside {2'h1, 2'h2} && $stable(direct_in))[*6]
      |-> channel_on_out == direct_in;
  endproperty
  a_follow: assert property (p_follow) else $error("channel not follow");
  property p_fslow;
    (mode_out == 2'h2)[*2] |-> !failsafe_output_n_out;
  endproperty
  a_fslow: assert property (p_fslow) else $error("fail-safe pin high");
  property p_fshigh;
    (mode_out == 2'h1)[*2] |-> failsafe_output_n_out;
  endproperty
  a_fshigh: assert property (p_fshigh) else $error("fail-safe pin low");
  property p_dl;
    delatch_out |=> !delatch_out ##[0:1] mode_out inside {2'h2, 2'h3};
  endproperty
  a_dl: assert property (p_dl) else $error("bad delatch pulse");
  c_fs: cover property (mode_out == 2'h2);
  c_flt: cover property (mode_out == 2'h3);
  c_dl: cover property (delatch_out);
endmodule : opmode_checker
bind operating_mode_supervisor opmode_checker u_chk (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .wake_reset_pin_n_in(wake_reset_pin_n_in), .direct_in(direct_in),
  .logic_supply_ok_in(logic_supply_ok_in),
  .overcurrent_fault_in(overcurrent_fault_in),
  .overtemperature_fault_in(overtemperature_fault_in),
  .severe_short_fault_in(severe_short_fault_in),
  .undervoltage_fault_in(undervoltage_fault_in),
  .supply_high_fault_in(supply_high_fault_in),
  .failsafe_output_n_out(failsafe_output_n_out),
  .channel_on_out(channel_on_out), .mode_out(mode_out),
  .delatch_out(delatch_out));
`default_nettype wire
